// ---- design/sidc_cfg.svh ----
// constants for the self-id capture and upper channel mask block
`ifndef SIDC_CFG_SVH
`define SIDC_CFG_SVH
`define SIDC_OFF_BASE 12'h064
`define SIDC_OFF_STAT 12'h068
`define SIDC_OFF_MSET 12'h070
`define SIDC_OFF_MCLR 12'h074
`define SIDC_OFF_IEVT 12'h080
`define SIDC_OFF_ICLR 12'h084
`define SIDC_OFF_IEN 12'h088
`define SIDC_ADDR_W 12
`define SIDC_BASE_LSB 11
`define SIDC_ERR_BIT 31
`define SIDC_GEN_LSB 16
`define SIDC_CNT_LSB 2
`define SIDC_CNT_W 9
`define SIDC_QUAD_BYTES 32'h0000_0004
`define SIDC_CHAN_HI 6'h20
`define SIDC_NUM_EVT 3
`define SIDC_EVT_RST 0
`define SIDC_EVT_DONE 1
`define SIDC_EVT_ERR 2
`endif

// ---- design/sidc_pkg.sv ----
// types for the self-id capture and upper channel mask block
package sidc_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sidc_apb_req_t;
    typedef struct packed {
        logic bus_reset;
        logic rx_begin;
        logic quad_valid;
        logic rx_end;
        logic hw_fault;
        logic host_wr_fail;
    } sidc_rx_evt_t;
    typedef struct packed {
        logic [31:0] addr;
        logic valid;
    } sidc_wr_t;
    typedef enum logic [0:0] {SIDC_IDLE, SIDC_RECV} sidc_state_t;
endpackage : sidc_pkg

// ---- design/sidc_top.sv ----
// self-id capture status, buffer pointer and upper iso channel mask with apb slave
`timescale 1ns/1ns
`include "sidc_cfg.svh"
module sidc_top
    import sidc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sidc_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sidc_rx_evt_t rx,
    input wire logic [5:0] iso_channel,
    input wire logic iso_valid,
    output logic iso_accept,
    output sidc_wr_t quad_wr,
    output logic irq
);
    logic [31:`SIDC_BASE_LSB] base_q;
    logic err_q;
    logic rx_err_q;
    logic [7:0] gen_q;
    logic [`SIDC_CNT_W-1:0] cnt_q;
    logic [31:0] mask_q;
    logic [`SIDC_NUM_EVT-1:0] evt_q;
    logic [`SIDC_NUM_EVT-1:0] ien_q;
    sidc_state_t state_q;
    logic [31:0] rd_d;
    logic err_d;
    logic acc_d;
    logic setup;
    logic wr_en;
    logic [`SIDC_NUM_EVT-1:0] evt_in;

    // setup phase of a transfer; the slave answers with zero wait states
    assign setup = apb.psel && !apb.penable;
    assign wr_en = apb.psel && apb.penable && apb.pwrite && !pslverr;
    assign evt_in = {rx.hw_fault || rx.host_wr_fail, rx.rx_end, rx.bus_reset};

    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (apb.paddr == `SIDC_OFF_BASE) begin
            rd_d[31:`SIDC_BASE_LSB] = base_q;
        end else if (apb.paddr == `SIDC_OFF_STAT) begin
            rd_d[`SIDC_ERR_BIT] = err_q;
            rd_d[`SIDC_GEN_LSB+:8] = gen_q;
            rd_d[`SIDC_CNT_LSB+:`SIDC_CNT_W] = cnt_q;
        end else if (apb.paddr == `SIDC_OFF_MSET || apb.paddr == `SIDC_OFF_MCLR) begin
            rd_d = mask_q;
        end else if (apb.paddr == `SIDC_OFF_IEVT) begin
            rd_d[`SIDC_NUM_EVT-1:0] = evt_q;
        end else if (apb.paddr == `SIDC_OFF_IEN) begin
            rd_d[`SIDC_NUM_EVT-1:0] = ien_q;
        end else if (apb.paddr == `SIDC_OFF_ICLR) begin
            rd_d = 32'h0000_0000;
        end else begin
            err_d = 1'b1;
        end
    end

    // apb answer registered in the setup cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && err_d;
            if (setup && !apb.pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_q <= '0;
        end else if (wr_en && apb.paddr == `SIDC_OFF_BASE) begin
            base_q <= apb.pwdata[31:`SIDC_BASE_LSB];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= 32'h0000_0000;
        end else if (wr_en && apb.paddr == `SIDC_OFF_MSET) begin
            mask_q <= mask_q | apb.pwdata;
        end else if (wr_en && apb.paddr == `SIDC_OFF_MCLR) begin
            mask_q <= mask_q & ~apb.pwdata;
        end
    end

    always_comb begin
        acc_d = 1'b0;
        if (iso_valid && iso_channel >= `SIDC_CHAN_HI) begin
            acc_d = mask_q[iso_channel[4:0]];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iso_accept <= 1'b0;
        end else begin
            iso_accept <= acc_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_q <= 8'h00;
        end else if (rx.bus_reset) begin
            gen_q <= gen_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SIDC_IDLE;
        end else begin
            case (state_q)
                SIDC_IDLE: begin
                    if (rx.rx_begin) begin
                        state_q <= SIDC_RECV;
                    end
                end
                SIDC_RECV: begin
                    if (rx.rx_end) begin
                        state_q <= SIDC_IDLE;
                    end
                end
                default: begin
                    state_q <= SIDC_IDLE;
                end
            endcase
        end
    end

    // quadlet counter and host write address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            quad_wr <= '0;
        end else if (rx.rx_begin) begin
            cnt_q <= '0;
            quad_wr <= '0;
        end else if (rx.quad_valid && state_q == SIDC_RECV) begin
            cnt_q <= cnt_q + `SIDC_CNT_W'(1);
            quad_wr.valid <= 1'b1;
            quad_wr.addr <= {base_q, {`SIDC_BASE_LSB{1'b0}}} + `SIDC_QUAD_BYTES * 32'(cnt_q);
        end else begin
            quad_wr.valid <= 1'b0;
        end
    end

    // error tracking for the reception in progress
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_err_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            // a fault in the start cycle still spoils the new reception
            if (rx.hw_fault || rx.host_wr_fail) begin
                rx_err_q <= 1'b1;
            end else if (rx.rx_begin) begin
                rx_err_q <= 1'b0;
            end
            if (rx.hw_fault || rx.host_wr_fail) begin
                err_q <= 1'b1;
            end else if (rx.rx_end && state_q == SIDC_RECV && !rx_err_q) begin
                err_q <= 1'b0;
            end
        end
    end

    // sticky events, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_q <= '0;
            ien_q <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_en && apb.paddr == `SIDC_OFF_ICLR) begin
                evt_q <= (evt_q & ~apb.pwdata[`SIDC_NUM_EVT-1:0]) | evt_in;
            end else begin
                evt_q <= evt_q | evt_in;
            end
            if (wr_en && apb.paddr == `SIDC_OFF_IEN) begin
                ien_q <= apb.pwdata[`SIDC_NUM_EVT-1:0];
            end
            irq <= |(evt_q & ien_q);
        end
    end
endmodule : sidc_top

// ---- verification/sidc_properties.sv ----
// checker for apb timing, status layout and capture addresses
`timescale 1ns/1ns
module sidc_properties
    import sidc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sidc_apb_req_t apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sidc_rx_evt_t rx,
    input wire logic [5:0] iso_channel,
    input wire logic iso_valid,
    input wire logic iso_accept,
    input wire sidc_wr_t quad_wr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rdy; apb.psel && !apb.penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("slave error without ready");
    property p_iso_lo; iso_valid && !iso_channel[5] |=> !iso_accept; endproperty
    a_iso_lo: assert property (p_iso_lo) else $error("lower channel accepted");
    property p_iso_idle; !iso_valid |=> !iso_accept; endproperty
    a_iso_idle: assert property (p_iso_idle) else $error("accept without packet");
    property p_qv; quad_wr.valid |-> $past(rx.quad_valid); endproperty
    a_qv: assert property (p_qv) else $error("quadlet write without cause");
    property p_qseq; quad_wr.valid ##2 quad_wr.valid |-> quad_wr.addr == $past(quad_wr.addr, 2) + 32'h4; endproperty
    a_qseq: assert property (p_qseq) else $error("quadlet addresses not consecutive");
    property p_qbeg; rx.rx_begin ##2 rx.quad_valid |=> quad_wr.addr[10:0] == 11'h0; endproperty
    a_qbeg: assert property (p_qbeg) else $error("first quadlet not at base");
    property p_base; pready && !apb.pwrite && apb.paddr == 12'h064 |-> prdata[10:0] == 11'h0; endproperty
    a_base: assert property (p_base) else $error("pointer low bits not zero");
    property p_stat; pready && !apb.pwrite && apb.paddr == 12'h068 |-> {prdata[30:24], prdata[15:11], prdata[1:0]} == 14'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status unused bits not zero");
endmodule : sidc_properties
bind sidc_top sidc_properties u_props (.clk(clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .iso_channel(iso_channel), .iso_valid(iso_valid), .iso_accept(iso_accept),
    .quad_wr(quad_wr));

// ---- verification/sidc_link_model.sv ----
// link-side model: self-id event pulses and iso packet channels
`timescale 1ns/1ns
module sidc_link_model
    import sidc_pkg::*;
(
    input wire logic clk,
    output sidc_rx_evt_t rx,
    output logic [5:0] iso_channel,
    output logic iso_valid
);
    initial begin
        rx = '0;
        iso_channel = 6'h0;
        iso_valid = 1'b0;
    end
    task automatic pulse(input sidc_rx_evt_t e);
        rx <= e;
        @(posedge clk);
        rx <= '0;
        @(posedge clk);
    endtask : pulse
    // header and data quadlets, optional fault mid-reception
    task automatic receive(input int n, input sidc_rx_evt_t f);
        pulse(6'h10);
        repeat (n) pulse(6'h08);
        pulse(f);
        pulse(6'h04);
    endtask : receive
    task automatic iso(input logic [5:0] ch);
        iso_channel <= ch;
        iso_valid <= 1'b1;
        @(posedge clk);
        iso_valid <= 1'b0;
        // released channel lines do not keep their value
        iso_channel <= ~ch;
    endtask : iso
endmodule : sidc_link_model

// ---- verification/selfid_capture_iso_mask_tb.sv ----
// self-checking bench for self-id capture status and upper channel mask
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, s); end end
module selfid_capture_iso_mask_tb;
    import sidc_pkg::*;
    logic clk = 0;
    logic rst = 1;
    sidc_apb_req_t apb = '0;
    logic [31:0] prdata, m, lf = 32'hF7D6;
    logic pready, pslverr, iso_accept, irq, iso_valid;
    logic [5:0] iso_channel;
    sidc_rx_evt_t rx;
    sidc_wr_t quad_wr;
    logic [32:0] expq[$];
    logic [32:0] rexp;
    logic [31:0] b, qa;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    sidc_top DUT (.clk(clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
        .iso_channel(iso_channel), .iso_valid(iso_valid), .iso_accept(iso_accept), .quad_wr(quad_wr), .irq(irq));
    sidc_link_model link (.clk(clk), .rx(rx), .iso_channel(iso_channel), .iso_valid(iso_valid));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        apb <= '0;
        @(posedge clk);
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    always @(posedge clk) if (pready === 1'b1 && apb.pwrite === 1'b0) begin
        rexp = expq.pop_front();
        `CHK("read", rexp, {pslverr, prdata})
    end
    always @(posedge clk) if (quad_wr.valid === 1'b1) begin
        `CHK("quad", qa, quad_wr.addr)
        qa = qa + 32'h0000_0004;
    end
    always @(posedge clk) if (++cyc == 6000) begin
        n_fail++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(12'h064 + 12'(4 * i), {i == 2, 32'h0});
        lf = lfsr(lf);
        xfer(1'b1, 12'h064, lf);
        b = lf & 32'hFFFF_F800;
        rd(12'h064, {1'b0, b});
        lf = lfsr(lf);
        m = lf;
        xfer(1'b1, 12'h070, m);
        rd(12'h074, {1'b0, m});
        lf = lfsr(lf);
        xfer(1'b1, 12'h074, lf);
        m = m & ~lf;
        rd(12'h070, {1'b0, m});
        $display("done registers");
        for (int c = 0; c < 64; c++) begin
            link.iso(6'(c));
            @(negedge clk);
            `CHK("accept", c[5] & m[c[4:0]], iso_accept)
            @(posedge clk);
        end
        $display("done channels");
        xfer(1'b1, 12'h088, 32'h7);
        link.pulse(6'h20);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        @(posedge clk);
        xfer(1'b1, 12'h084, 32'h7);
        xfer(1'b1, 12'h088, 32'h0);
        link.pulse(6'h20);
        rd(12'h080, 33'h1);
        @(negedge clk);
        `CHK("irq", 1'b0, irq)
        @(posedge clk);
        $display("done interrupts");
        for (int i = 0; i < 3; i++) begin
            qa = b;
            link.receive(i + 2, 6'h2 >> i);
            rd(12'h068, {1'b0, i < 2, 15'h2, 5'h0, 9'(i + 2), 2'h0});
        end
        repeat (254) link.pulse(6'h20);
        rd(12'h068, 33'h10);
        $display("done capture");
        summarize();
    end
endmodule : selfid_capture_iso_mask_tb
